// ---- dtov_consts.vh ----
// Constants of the definite-time overvoltage trip block
`ifndef DTOV_CONSTS_VH
`define DTOV_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DTOV_OFS_CTRL 5'h00
`define DTOV_OFS_THR 5'h04
`define DTOV_OFS_DLY 5'h08
`define DTOV_OFS_STAT 5'h0C
`define DTOV_OFS_ISTAT 5'h10
`define DTOV_OFS_IMASK 5'h14

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define DTOV_CTRL_STONLY 0
`define DTOV_CTRL_RENA 1
`define DTOV_CTRL_RSTONLY 2
`define DTOV_CTRL_DELTA 3
`define DTOV_CTRL_RST 4'h2

// ----------------------------------------------------------------
// Residual settings
// ----------------------------------------------------------------
`define DTOV_THR_MIN 6'h02
`define DTOV_THR_MAX 6'h3C
`define DTOV_THR_RST 6'h1E
`define DTOV_DLY_MAX 16'hEA60
`define DTOV_DLY_RST 16'h0064
`define DTOV_PCT_SCALE 8'h64

// ----------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------
`define DTOV_EV_GST 0
`define DTOV_EV_GTR 1
`define DTOV_EV_RST_ST 2
`define DTOV_EV_RTR 3
`define DTOV_EV_W 4
`define DTOV_IMASK_RST 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DTOV_CLK_NS 10
`define DTOV_TICK_NS 1000000
`define DTOV_MS_CYCLES (`DTOV_TICK_NS / `DTOV_CLK_NS)

`endif

// ---- dtov_resid.v ----
// Residual overvoltage start and delay timer stage
`timescale 1ns/10ps
`default_nettype none

module dtov_resid #(
    parameter RMS_W = 16,
    parameter DLY_W = 16,
    parameter [7:0] PCT_SCALE = 8'h64
) (
    input wire mclk,
    input wire rst,
    input wire ms_tick,
    input wire enable,
    input wire block,
    input wire [RMS_W-1:0] residual_rms_in,
    input wire [5:0] thr_pct,
    input wire [DLY_W-1:0] delay_ms,
    output reg residual_start,
    output reg residual_trip
);

// ----------------------------------------------------------------
// Threshold compare
// ----------------------------------------------------------------
wire [13:0] thr_lvl;
wire over;
reg [DLY_W-1:0] cnt_ff;
reg [DLY_W-1:0] nxt_cnt;

assign thr_lvl = thr_pct * PCT_SCALE;
// Precomputed magnitude compared directly
assign over = enable & ~block & (residual_rms_in > {{(RMS_W-14){1'b0}}, thr_lvl});

// ----------------------------------------------------------------
// Delay timer
// ----------------------------------------------------------------
always @* begin
    nxt_cnt = cnt_ff;
    if (!over) begin
        nxt_cnt = {DLY_W{1'b0}};
    end else if (ms_tick && cnt_ff <= delay_ms) begin
        nxt_cnt = cnt_ff + {{(DLY_W-1){1'b0}}, 1'b1};
    end
end

always @(posedge mclk) begin
    if (rst) begin
        cnt_ff <= {DLY_W{1'b0}};
        residual_start <= 1'b0;
        residual_trip <= 1'b0;
    end else begin
        cnt_ff <= nxt_cnt;
        residual_start <= over;
        // First tick may come at once, so a full delay needs one tick more
        residual_trip <= over & ((delay_ms == {DLY_W{1'b0}}) | (nxt_cnt > delay_ms));
    end
end

endmodule // dtov_resid

`default_nettype wire

// ---- dtov_top.v ----
// Definite-time overvoltage decision logic with register slave
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dtov_consts.vh"

module dtov_top #(
    parameter MS_CYCLES = `DTOV_MS_CYCLES,
    parameter RMS_W = 16
) (
    input wire mclk,
    input wire rst,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire phase_a_start_in,
    input wire phase_b_start_in,
    input wire phase_c_start_in,
    input wire phase_a_trip_in,
    input wire phase_b_trip_in,
    input wire phase_c_trip_in,
    input wire block_in,
    input wire [RMS_W-1:0] residual_rms_in,
    input wire residual_block_in,
    output reg phase_a_start,
    output reg phase_b_start,
    output reg phase_c_start,
    output reg general_start,
    output reg general_trip,
    output reg residual_general_start,
    output reg residual_general_trip,
    output reg irq
);

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg [3:0] ctrl_ff;
reg [5:0] thr_ff;
reg [15:0] dly_ff;
reg [`DTOV_EV_W-1:0] istat_ff;
reg [`DTOV_EV_W-1:0] imask_ff;
reg [`DTOV_EV_W-1:0] prev_ff;
reg [31:0] ms_cnt_ff;
reg ms_tick_ff;
reg [31:0] nxt_rdata;
reg [31:0] wmask;
reg [31:0] ctrl_wv;
reg [31:0] thr_wv;
reg [31:0] dly_wv;
reg [31:0] imask_wv;
reg [5:0] nxt_thr;
reg [15:0] nxt_dly;
reg [`DTOV_EV_W-1:0] nxt_istat;
reg [`DTOV_EV_W-1:0] w1c;
reg [`DTOV_EV_W-1:0] nxt_imask;
wire acc_wr;
wire start_only;
wire res_enable;
wire res_start_only;
wire ph_any_start;
wire ph_any_trip;
wire nxt_gstart;
wire nxt_gtrip;
wire res_start;
wire res_trip;
wire nxt_rgstart;
wire nxt_rgtrip;
wire [`DTOV_EV_W-1:0] ev_level;
wire [`DTOV_EV_W-1:0] ev_rise;

// ----------------------------------------------------------------
// Millisecond enable divider
// ----------------------------------------------------------------
always @(posedge mclk) begin
    if (rst) begin
        ms_cnt_ff <= 32'h00000000;
        ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff == MS_CYCLES - 1) begin
        ms_cnt_ff <= 32'h00000000;
        ms_tick_ff <= 1'b1;
    end else begin
        ms_cnt_ff <= ms_cnt_ff + 32'h00000001;
        ms_tick_ff <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Settings decode
// ----------------------------------------------------------------
assign start_only = ctrl_ff[`DTOV_CTRL_STONLY];
assign res_enable = ctrl_ff[`DTOV_CTRL_RENA];
assign res_start_only = ctrl_ff[`DTOV_CTRL_RSTONLY];

// ----------------------------------------------------------------
// Three-phase decision
// ----------------------------------------------------------------
// Channels a, b, c carry L12, L23, L31 when delta mode is set
assign ph_any_start = phase_a_start_in | phase_b_start_in | phase_c_start_in;
assign ph_any_trip = phase_a_trip_in | phase_b_trip_in | phase_c_trip_in;
assign nxt_gstart = ph_any_start & ~block_in;
assign nxt_gtrip = ph_any_trip & ~start_only & ~block_in;

// ----------------------------------------------------------------
// Residual stage
// ----------------------------------------------------------------
dtov_resid #(
    .RMS_W(RMS_W),
    .DLY_W(16),
    .PCT_SCALE(`DTOV_PCT_SCALE)
) u_resid (
    .mclk(mclk),
    .rst(rst),
    .ms_tick(ms_tick_ff),
    .enable(res_enable),
    .block(residual_block_in),
    .residual_rms_in(residual_rms_in),
    .thr_pct(thr_ff),
    .delay_ms(dly_ff),
    .residual_start(res_start),
    .residual_trip(res_trip)
);

assign nxt_rgstart = res_start & ~residual_block_in;
assign nxt_rgtrip = res_trip & ~res_start_only & ~residual_block_in;

// ----------------------------------------------------------------
// Three-phase outputs
// ----------------------------------------------------------------
// Block input silences every three-phase output
always @(posedge mclk) begin
    if (rst) begin
        phase_a_start <= 1'b0;
        phase_b_start <= 1'b0;
        phase_c_start <= 1'b0;
        general_start <= 1'b0;
        general_trip <= 1'b0;
    end else begin
        phase_a_start <= phase_a_start_in & ~block_in;
        phase_b_start <= phase_b_start_in & ~block_in;
        phase_c_start <= phase_c_start_in & ~block_in;
        general_start <= nxt_gstart;
        general_trip <= nxt_gtrip;
    end
end

// ----------------------------------------------------------------
// Residual outputs
// ----------------------------------------------------------------
always @(posedge mclk) begin
    if (rst) begin
        residual_general_start <= 1'b0;
        residual_general_trip <= 1'b0;
    end else begin
        residual_general_start <= nxt_rgstart;
        residual_general_trip <= nxt_rgtrip;
    end
end

// ----------------------------------------------------------------
// Interrupt events
// ----------------------------------------------------------------
assign ev_level = {nxt_rgtrip, nxt_rgstart, nxt_gtrip, nxt_gstart};
assign ev_rise = ev_level & ~prev_ff;

always @* begin
    w1c = {`DTOV_EV_W{1'b0}};
    if (acc_wr && avs_address == `DTOV_OFS_ISTAT && avs_byteenable[0]) begin
        w1c = avs_writedata[`DTOV_EV_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    nxt_istat = (istat_ff & ~w1c) | ev_rise;
end

always @(posedge mclk) begin
    if (rst) begin
        prev_ff <= {`DTOV_EV_W{1'b0}};
        istat_ff <= {`DTOV_EV_W{1'b0}};
        irq <= 1'b0;
    end else begin
        prev_ff <= ev_level;
        istat_ff <= nxt_istat;
        irq <= |(nxt_istat & nxt_imask);
    end
end

// ----------------------------------------------------------------
// Avalon slave handshake
// ----------------------------------------------------------------
// Waitrequest drops for one cycle; the access acts on that edge
assign acc_wr = avs_write & ~avs_waitrequest;

always @(posedge mclk) begin
    if (rst) begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h00000000;
    end else if ((avs_read | avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= nxt_rdata;
    end else begin
        avs_waitrequest <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @* begin
    nxt_rdata = 32'h00000000;
    case (avs_address)
        `DTOV_OFS_CTRL: begin
            nxt_rdata = {28'h0000000, ctrl_ff};
        end
        `DTOV_OFS_THR: begin
            nxt_rdata = {26'h0000000, thr_ff};
        end
        `DTOV_OFS_DLY: begin
            nxt_rdata = {16'h0000, dly_ff};
        end
        `DTOV_OFS_STAT: begin
            nxt_rdata = {23'h000000, res_trip, res_start,
                residual_general_trip, residual_general_start,
                general_trip, general_start,
                phase_c_start, phase_b_start, phase_a_start};
        end
        `DTOV_OFS_ISTAT: begin
            nxt_rdata = {28'h0000000, istat_ff};
        end
        `DTOV_OFS_IMASK: begin
            nxt_rdata = {28'h0000000, imask_ff};
        end
        default: begin
            nxt_rdata = 32'h00000000;
        end
    endcase
end

// ----------------------------------------------------------------
// Write merge and range clamps
// ----------------------------------------------------------------
always @* begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    ctrl_wv = ({28'h0000000, ctrl_ff} & ~wmask) | (avs_writedata & wmask);
    thr_wv = ({26'h0000000, thr_ff} & ~wmask) | (avs_writedata & wmask);
    dly_wv = ({16'h0000, dly_ff} & ~wmask) | (avs_writedata & wmask);
    imask_wv = ({28'h0000000, imask_ff} & ~wmask) | (avs_writedata & wmask);
    // A mask write reaches irq on the same edge
    nxt_imask = imask_ff;
    if (acc_wr && avs_address == `DTOV_OFS_IMASK) begin
        nxt_imask = imask_wv[`DTOV_EV_W-1:0];
    end
    if (thr_wv < {26'h0000000, `DTOV_THR_MIN}) begin
        nxt_thr = `DTOV_THR_MIN;
    end else if (thr_wv > {26'h0000000, `DTOV_THR_MAX}) begin
        nxt_thr = `DTOV_THR_MAX;
    end else begin
        nxt_thr = thr_wv[5:0];
    end
    if (dly_wv > {16'h0000, `DTOV_DLY_MAX}) begin
        nxt_dly = `DTOV_DLY_MAX;
    end else begin
        nxt_dly = dly_wv[15:0];
    end
end

// ----------------------------------------------------------------
// Setting registers
// ----------------------------------------------------------------
always @(posedge mclk) begin
    if (rst) begin
        ctrl_ff <= `DTOV_CTRL_RST;
        thr_ff <= `DTOV_THR_RST;
        dly_ff <= `DTOV_DLY_RST;
        imask_ff <= `DTOV_IMASK_RST;
    end else if (acc_wr) begin
        case (avs_address)
            `DTOV_OFS_CTRL: begin
                ctrl_ff <= ctrl_wv[3:0];
            end
            `DTOV_OFS_THR: begin
                thr_ff <= nxt_thr;
            end
            `DTOV_OFS_DLY: begin
                dly_ff <= nxt_dly;
            end
            `DTOV_OFS_IMASK: begin
                imask_ff <= nxt_imask;
            end
            default: begin
                imask_ff <= imask_ff;
            end
        endcase
    end
end

endmodule // dtov_top

`default_nettype wire

// ---- dtov_asserts.sv ----
// Concurrent checks on the overvoltage trip block ports
`timescale 1ns/10ps
`default_nettype none
module dtov_asserts #(
    parameter MS_CYCLES = 10,
    parameter RMS_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic phase_a_start_in,
    input wire logic phase_b_start_in,
    input wire logic phase_c_start_in,
    input wire logic phase_a_trip_in,
    input wire logic phase_b_trip_in,
    input wire logic phase_c_trip_in,
    input wire logic block_in,
    input wire logic [RMS_W-1:0] residual_rms_in,
    input wire logic residual_block_in,
    input wire logic phase_a_start,
    input wire logic phase_b_start,
    input wire logic general_start,
    input wire logic general_trip,
    input wire logic residual_general_start,
    input wire logic residual_general_trip
);
    // ----------------------------------------
    // Helpers and clocking
    // ----------------------------------------
    wire logic any_st = phase_a_start_in | phase_b_start_in | phase_c_start_in;
    wire logic any_tr = phase_a_trip_in | phase_b_trip_in | phase_c_trip_in;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    gen_start_a: assert property (!$past(rst) |->
        general_start == $past(any_st & !block_in)) else $error("general start wrong");
    phase_start_a: assert property (!$past(rst) |->
        phase_a_start == $past(phase_a_start_in & !block_in)) else $error("phase start wrong");
    gen_trip_a: assert property (general_trip |->
        $past(any_tr & !block_in)) else $error("trip without cause");
    block_quiet_a: assert property (block_in |=>
        !general_start && !general_trip && !phase_b_start) else $error("blocked output");
    res_start_a: assert property (residual_general_start |->
        $past(residual_rms_in, 2) > 200 && !$past(residual_block_in)) else $error("bad start");
    res_trip_a: assert property (residual_general_trip && !$past(residual_block_in) |->
        residual_general_start) else $error("residual trip without start");
    res_block_a: assert property (residual_block_in [*2] |=>
        !residual_general_start && !residual_general_trip) else $error("residual not cleared");
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    wait_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no bus answer");
    wait_spur_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
endmodule // dtov_asserts
bind dtov_top dtov_asserts #(.MS_CYCLES(MS_CYCLES), .RMS_W(RMS_W)) chk (.mclk(mclk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .phase_a_start_in(phase_a_start_in), .phase_b_start_in(phase_b_start_in),
    .phase_c_start_in(phase_c_start_in), .phase_a_trip_in(phase_a_trip_in),
    .phase_b_trip_in(phase_b_trip_in), .phase_c_trip_in(phase_c_trip_in),
    .block_in(block_in), .residual_rms_in(residual_rms_in),
    .residual_block_in(residual_block_in), .phase_a_start(phase_a_start),
    .phase_b_start(phase_b_start), .general_start(general_start), .general_trip(general_trip),
    .residual_general_start(residual_general_start),
    .residual_general_trip(residual_general_trip));
`default_nettype wire

// ---- dtov_front.sv ----
// Measurement front end and user block logic feeding the trip block
`timescale 1ns/10ps
`default_nettype none
module dtov_front (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] want_flags,
    input wire logic [15:0] want_rms,
    output logic [7:0] flags_ff,
    output logic [15:0] rms_ff
);
    // ----------------------------------------
    // Registered flags, block levels and residual RMS
    // ----------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            flags_ff <= 8'h00;
            rms_ff <= 16'h0000;
        end else begin
            flags_ff <= want_flags;
            rms_ff <= want_rms;
        end
    end
endmodule // dtov_front
`default_nettype wire

// ---- definite_time_overvoltage_trip_bench.sv ----
// Self-checking bench for the overvoltage trip block
`timescale 1ns/10ps
`default_nettype none
module definite_time_overvoltage_trip_bench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest;
    logic [7:0] want_flags = 8'h00;
    logic [15:0] want_rms = 16'h0000;
    wire logic [7:0] fl;
    wire logic [15:0] rms;
    wire logic [7:0] pins;
    logic smp = 1'b0;
    logic [31:0] q[$];
    int fail_count = 0;
    int checked = 0;
    int i;
    logic [8:0] r;
    logic [2:0] st;
    logic [15:0] v;
    always #5 mclk = ~mclk;
    // ----------------------------------------
    // Design and front end
    // ----------------------------------------
    dtov_front fe (.mclk(mclk), .rst(rst), .want_flags(want_flags), .want_rms(want_rms),
        .flags_ff(fl), .rms_ff(rms));
    dtov_top #(.MS_CYCLES(10)) dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .phase_a_start_in(fl[0]), .phase_b_start_in(fl[1]), .phase_c_start_in(fl[2]),
        .phase_a_trip_in(fl[3]), .phase_b_trip_in(fl[4]), .phase_c_trip_in(fl[5]),
        .block_in(fl[6]), .residual_rms_in(rms), .residual_block_in(fl[7]),
        .phase_a_start(pins[0]), .phase_b_start(pins[1]), .phase_c_start(pins[2]),
        .general_start(pins[3]), .general_trip(pins[4]), .residual_general_start(pins[5]),
        .residual_general_trip(pins[6]), .irq(pins[7]));
    // ----------------------------------------
    // Scoreboard
    // ----------------------------------------
    task automatic cmp(input logic [31:0] got);
        logic [31:0] exp;
        exp = q.pop_front();
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata);
        if (smp) cmp({24'h0, pins});
    end
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        q.push_back(e);
        acc(1'b0, a, 32'h0);
    endtask
    task automatic put(input logic [7:0] f, input logic [15:0] x, input int n);
        want_flags <= f;
        want_rms <= x;
        repeat (n) @(posedge mclk);
    endtask
    task automatic look(input logic [7:0] e);
        q.push_back({24'h0, e});
        smp <= 1'b1;
        @(posedge mclk);
        smp <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        fail_count++;
        give_verdict;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        i = $urandom(43);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(5'h00, 32'h2);
        rd(5'h04, 32'h1E);
        rd(5'h08, 32'h64);
        rd(5'h1C, 32'h0);
        acc(1'b1, 5'h04, 32'h3F);
        rd(5'h04, 32'h3C);
        acc(1'b1, 5'h04, 32'h0);
        rd(5'h04, 32'h2);
        acc(1'b1, 5'h08, 32'hFFFF);
        rd(5'h08, 32'hEA60);
        for (i = 0; i < 24; i++) begin
            r = 9'($urandom);
            acc(1'b1, 5'h00, {28'h0, r[8], 1'b0, 1'b1, r[7]});
            put({1'b0, r[6:0]}, 16'h0, 3);
            st = r[2:0] & {3{!r[6]}};
            look({3'b000, |r[5:3] & !r[7] & !r[6], |st, st});
        end
        put(8'h00, 16'h0, 3);
        acc(1'b1, 5'h10, 32'hF);
        acc(1'b1, 5'h14, 32'h4);
        acc(1'b1, 5'h00, 32'h2);
        acc(1'b1, 5'h04, 32'h5);
        acc(1'b1, 5'h08, 32'h3);
        v = 16'(32'h01F5 + $urandom % 32'h0BB8);
        put(8'h00, v, 5);
        look(8'hA0);
        put(8'h00, v, 20);
        look(8'hA0);
        put(8'h00, v, 20);
        look(8'hE0);
        rd(5'h0C, 32'h1E0);
        rd(5'h10, 32'hC);
        acc(1'b1, 5'h10, 32'h4);
        rd(5'h10, 32'h8);
        look(8'h60);
        put(8'h00, 16'h01F4, 4);
        look(8'h00);
        acc(1'b1, 5'h00, 32'h6);
        put(8'h00, v, 45);
        look(8'hA0);
        put(8'h80, v, 4);
        look(8'h80);
        acc(1'b1, 5'h00, 32'h0);
        acc(1'b1, 5'h10, 32'hF);
        put(8'h00, v, 45);
        look(8'h00);
        acc(1'b1, 5'h00, 32'h2);
        acc(1'b1, 5'h08, 32'h0);
        put(8'h00, 16'h0, 3);
        put(8'h00, v, 4);
        look(8'hE0);
        give_verdict;
    end
endmodule // definite_time_overvoltage_trip_bench
`default_nettype wire
